// >>> design/fpio_defines.vh
// fpio_defines.vh: register offsets, field positions, reset values for the four port parallel io block
// assumes: included by the fpio design files only
`ifndef FPIO_DEFINES_VH
`define FPIO_DEFINES_VH

// register indices, byte address is four times the index
`define FPIO_IDX_PTA_DATA 4'h0
`define FPIO_IDX_PTB_DATA 4'h1
`define FPIO_IDX_PTC_DATA 4'h2
`define FPIO_IDX_PTD_DATA 4'h3
`define FPIO_IDX_PTA_DIR 4'h4
`define FPIO_IDX_PTB_DIR 4'h5
`define FPIO_IDX_PTC_DIR 4'h6
`define FPIO_IDX_PTD_DIR 4'h7
`define FPIO_IDX_LED 4'hc
// own register holding the converter, bus and serial takeover controls
`define FPIO_IDX_ALT 4'hd

// widths
`define FPIO_PORT_W 8
`define FPIO_NPORT 4
`define FPIO_LED_W 7

// reset values
`define FPIO_DIR_RST 8'h00
`define FPIO_LED_RST 8'h00
`define FPIO_ALT_RST 8'h00

// alternate control register fields
`define FPIO_ALT_ADC_EN 5
`define FPIO_ALT_ADC_CH_HI 2
`define FPIO_ALT_ADC_CH_LO 0
`define FPIO_ALT_BUS_EN 6
`define FPIO_ALT_SCI_EN 7

// peripheral pin positions on port b
`define FPIO_PB_SDA 0
`define FPIO_PB_SCL 1
`define FPIO_PB_TXD 2
`define FPIO_PB_RXD 3
`define FPIO_PB_T1C0 4
`define FPIO_PB_T1C1 5

`endif

// >>> design/fpio_sync.v
// fpio_sync.v: two flip-flop synchroniser for a vector of pin inputs
// assumes: pins are asynchronous to clk_i, no reset needed on the chain
`timescale 1ns/100ps
`default_nettype none
module fpio_sync #(
  parameter W = 8
) (
  input wire clk_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (ce_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> design/fpio_pin.v
// fpio_pin.v: per-port pin control, one bit slice generated per pin
// assumes: direction and latch come from the register file, takeover masks from it and the timer edge selects, all on the same clock
`timescale 1ns/100ps
`default_nettype none
module fpio_pin (
  input wire [7:0] data_i,
  input wire [7:0] dir_i,
  input wire [7:0] analog_i,
  input wire [7:0] alt_sel_i,
  input wire [7:0] alt_out_i,
  input wire [7:0] alt_oe_i,
  input wire [7:0] od_i,
  input wire [7:0] pin_sync_i,
  output wire [7:0] out_o,
  output wire [7:0] oe_o,
  output wire [7:0] rd_o
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      wire drv_hi;
      wire drv_en;
      // gpio value or peripheral value
      assign drv_hi = alt_sel_i[i] ? alt_out_i[i] : data_i[i];
      // analog selection beats every digital control; open-drain only drives low
      assign drv_en = analog_i[i] ? 1'b0 :
        (alt_sel_i[i] ? (alt_oe_i[i] & ~(od_i[i] & drv_hi)) : (dir_i[i] & ~(od_i[i] & drv_hi)));
      assign out_o[i] = od_i[i] ? 1'b0 : drv_hi;
      assign oe_o[i] = drv_en;
      // outputs read back the latch, inputs read the pin
      assign rd_o[i] = dir_i[i] ? data_i[i] : pin_sync_i[i];
    end
  endgenerate
endmodule
`default_nettype wire

// >>> design/fpio_top.v
// fpio_top.v: four 8-bit general purpose ports with direction, led drive and peripheral takeover
// assumes: classic wishbone slave on clk_i, pins resolved outside from out/oe pairs
// assumes: peripheral drive values arrive on clk_i, pin levels arrive from any clock
// How it works
// - thirty-two two-way pins in four ports of eight bits
// - each pin is set as input or output by software
// - data registers at index 0 to 3, untouched by reset
// - direction registers at index 4 to 7, cleared on reset
// - led drive register at index c, seven enables, reset to zero
// - port b bits 0 and 1 carry sda and scl when bus enabled
// - port b bits 4 and 5 serve timer one channels when edge select nonzero
// - direction one enables the driver, zero makes the pin an input
// - converter channel selection overrides port logic on that pin
// - serial bus and serial interface pins drive open-drain only
`timescale 1ns/100ps
`default_nettype none
`include "fpio_defines.vh"
module fpio_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  // pins
  input wire [7:0] pa_in_i,
  input wire [7:0] pb_in_i,
  input wire [7:0] pc_in_i,
  input wire [7:0] pd_in_i,
  output reg [7:0] pa_out_o,
  output reg [7:0] pb_out_o,
  output reg [7:0] pc_out_o,
  output reg [7:0] pd_out_o,
  output reg [7:0] pa_oe_o,
  output reg [7:0] pb_oe_o,
  output reg [7:0] pc_oe_o,
  output reg [7:0] pd_oe_o,
  output reg [6:0] led_drive_o,
  // peripheral side, same clock
  input wire sda_out_i,
  input wire scl_out_i,
  input wire txd_out_i,
  input wire [1:0] ch0_edge_level_select_i,
  input wire [1:0] ch1_edge_level_select_i,
  input wire t1c0_out_i,
  input wire t1c0_oe_i,
  input wire t1c1_out_i,
  input wire t1c1_oe_i,
  output reg [7:0] port_b_alt_in_o
);
  // ***************************************
  // registers
  // ***************************************
  reg [7:0] port_a_data_reg;
  reg [7:0] port_b_data_reg;
  reg [7:0] port_c_data_reg;
  reg [7:0] port_d_data_reg;
  reg [7:0] port_a_dir_reg;
  reg [7:0] port_b_dir_reg;
  reg [7:0] port_c_dir_reg;
  reg [7:0] port_d_dir_reg;
  reg [6:0] led_drive_enable;
  reg [7:0] alt_ctrl_reg;

  wire [31:0] pin_raw;
  wire [7:0] pb_sync;
  wire [31:0] out_all;
  wire [31:0] oe_all;
  wire [31:0] rd_all;
  wire [31:0] pin_all;
  wire [31:0] data_all;
  wire [31:0] dir_all;
  wire [31:0] analog_all;
  wire [31:0] alt_sel_all;
  wire [31:0] alt_out_all;
  wire [31:0] alt_oe_all;
  wire [31:0] od_all;
  wire [3:0] idx;
  wire req;
  wire wr;
  wire mapped;
  reg [7:0] rd_byte;

  assign idx = adr_i[5:2];
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  // a write with the low byte lane off is still acknowledged but changes nothing
  assign wr = req & we_i & sel_i[0] & mapped;

  // ***************************************
  // pin synchronisers
  // ***************************************
  // pins are asynchronous, so nothing below reads pin_raw directly
  assign pin_raw = {pd_in_i, pc_in_i, pb_in_i, pa_in_i};
  fpio_sync #(.W(32)) u_sync (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .d_i(pin_raw),
    .q_o(pin_all)
  );
  // peripherals on port b see the same synchronised levels as the read path
  assign pb_sync = pin_all[15:8];

  // ***************************************
  // takeover masks
  // ***************************************
  wire adc_on;
  wire bus_on;
  wire sci_on;
  wire t1_0_on;
  wire t1_1_on;
  wire [7:0] adc_mask;
  wire [7:0] pb_sel;
  wire [7:0] pb_alt_out;
  wire [7:0] pb_alt_oe;
  wire [7:0] pb_od;
  assign adc_on = alt_ctrl_reg[`FPIO_ALT_ADC_EN];
  assign bus_on = alt_ctrl_reg[`FPIO_ALT_BUS_EN];
  assign sci_on = alt_ctrl_reg[`FPIO_ALT_SCI_EN];
  assign t1_0_on = |ch0_edge_level_select_i;
  assign t1_1_on = |ch1_edge_level_select_i;
  // one port a pin per selected converter channel
  assign adc_mask = adc_on ? (8'h01 << alt_ctrl_reg[`FPIO_ALT_ADC_CH_HI:`FPIO_ALT_ADC_CH_LO]) : 8'h00;
  // which port b pins a peripheral has taken over
  assign pb_sel[`FPIO_PB_SDA] = bus_on;
  assign pb_sel[`FPIO_PB_SCL] = bus_on;
  assign pb_sel[`FPIO_PB_TXD] = sci_on;
  assign pb_sel[`FPIO_PB_RXD] = sci_on;
  assign pb_sel[`FPIO_PB_T1C0] = t1_0_on;
  assign pb_sel[`FPIO_PB_T1C1] = t1_1_on;
  assign pb_sel[7:6] = 2'b00;
  // value each peripheral wants on its pin
  assign pb_alt_out[`FPIO_PB_SDA] = sda_out_i;
  assign pb_alt_out[`FPIO_PB_SCL] = scl_out_i;
  assign pb_alt_out[`FPIO_PB_TXD] = txd_out_i;
  assign pb_alt_out[`FPIO_PB_RXD] = 1'b0;
  assign pb_alt_out[`FPIO_PB_T1C0] = t1c0_out_i;
  assign pb_alt_out[`FPIO_PB_T1C1] = t1c1_out_i;
  assign pb_alt_out[7:6] = 2'b00;
  // bus and transmit lines may always pull low; receive pin never driven by the port
  assign pb_alt_oe[`FPIO_PB_SDA] = 1'b1;
  assign pb_alt_oe[`FPIO_PB_SCL] = 1'b1;
  assign pb_alt_oe[`FPIO_PB_TXD] = 1'b1;
  assign pb_alt_oe[`FPIO_PB_RXD] = 1'b0;
  assign pb_alt_oe[`FPIO_PB_T1C0] = t1c0_oe_i;
  assign pb_alt_oe[`FPIO_PB_T1C1] = t1c1_oe_i;
  assign pb_alt_oe[7:6] = 2'b00;
  // open-drain marks: a shared line must never be driven high against another device
  assign pb_od[`FPIO_PB_SDA] = bus_on;
  assign pb_od[`FPIO_PB_SCL] = bus_on;
  assign pb_od[`FPIO_PB_TXD] = sci_on;
  assign pb_od[`FPIO_PB_RXD] = sci_on;
  assign pb_od[`FPIO_PB_T1C0] = 1'b0;
  assign pb_od[`FPIO_PB_T1C1] = 1'b0;
  assign pb_od[7:6] = 2'b00;

  assign data_all = {port_d_data_reg, port_c_data_reg, port_b_data_reg, port_a_data_reg};
  assign dir_all = {port_d_dir_reg, port_c_dir_reg, port_b_dir_reg, port_a_dir_reg};
  assign analog_all = {24'h000000, adc_mask};
  assign alt_sel_all = {16'h0000, pb_sel, 8'h00};
  assign alt_out_all = {16'h0000, pb_alt_out, 8'h00};
  assign alt_oe_all = {16'h0000, pb_alt_oe, 8'h00};
  assign od_all = {16'h0000, pb_od, 8'h00};

  // ***************************************
  // per-port pin logic
  // ***************************************
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      fpio_pin u_pin (
        .data_i(data_all[8*p+7:8*p]),
        .dir_i(dir_all[8*p+7:8*p]),
        .analog_i(analog_all[8*p+7:8*p]),
        .alt_sel_i(alt_sel_all[8*p+7:8*p]),
        .alt_out_i(alt_out_all[8*p+7:8*p]),
        .alt_oe_i(alt_oe_all[8*p+7:8*p]),
        .od_i(od_all[8*p+7:8*p]),
        .pin_sync_i(pin_all[8*p+7:8*p]),
        .out_o(out_all[8*p+7:8*p]),
        .oe_o(oe_all[8*p+7:8*p]),
        .rd_o(rd_all[8*p+7:8*p])
      );
    end
  endgenerate

  // ***************************************
  // register read decode
  // ***************************************
  assign mapped = (idx <= `FPIO_IDX_PTD_DIR) || (idx == `FPIO_IDX_LED) || (idx == `FPIO_IDX_ALT);

  always @* begin
    case (idx)
      `FPIO_IDX_PTA_DATA: rd_byte = rd_all[7:0];
      `FPIO_IDX_PTB_DATA: rd_byte = rd_all[15:8];
      `FPIO_IDX_PTC_DATA: rd_byte = rd_all[23:16];
      `FPIO_IDX_PTD_DATA: rd_byte = rd_all[31:24];
      `FPIO_IDX_PTA_DIR: rd_byte = port_a_dir_reg;
      `FPIO_IDX_PTB_DIR: rd_byte = port_b_dir_reg;
      `FPIO_IDX_PTC_DIR: rd_byte = port_c_dir_reg;
      `FPIO_IDX_PTD_DIR: rd_byte = port_d_dir_reg;
      `FPIO_IDX_LED: rd_byte = {1'b0, led_drive_enable};
      `FPIO_IDX_ALT: rd_byte = alt_ctrl_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  // ***************************************
  // data latches: no reset, power-up value is unknown
  // ***************************************
  always @(posedge clk_i) begin
    if (ce_i && wr) begin
      case (idx)
        `FPIO_IDX_PTA_DATA: port_a_data_reg <= dat_i[7:0];
        `FPIO_IDX_PTB_DATA: port_b_data_reg <= dat_i[7:0];
        `FPIO_IDX_PTC_DATA: port_c_data_reg <= dat_i[7:0];
        `FPIO_IDX_PTD_DATA: port_d_data_reg <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ***************************************
  // control registers
  // ***************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_a_dir_reg <= `FPIO_DIR_RST;
      port_b_dir_reg <= `FPIO_DIR_RST;
      port_c_dir_reg <= `FPIO_DIR_RST;
      port_d_dir_reg <= `FPIO_DIR_RST;
      led_drive_enable <= 7'h00;
      alt_ctrl_reg <= `FPIO_ALT_RST;
    end else if (ce_i) begin
      if (wr) begin
        case (idx)
          `FPIO_IDX_PTA_DIR: port_a_dir_reg <= dat_i[7:0];
          `FPIO_IDX_PTB_DIR: port_b_dir_reg <= dat_i[7:0];
          `FPIO_IDX_PTC_DIR: port_c_dir_reg <= dat_i[7:0];
          `FPIO_IDX_PTD_DIR: port_d_dir_reg <= dat_i[7:0];
          `FPIO_IDX_LED: led_drive_enable <= dat_i[6:0];
          `FPIO_IDX_ALT: alt_ctrl_reg <= dat_i[7:0];
          default: ;
        endcase
      end
    end
  end

  // ***************************************
  // bus answer
  // ***************************************
  // registered, so ack or err always comes one cycle after the request is taken
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      // unmapped indices are refused with err and never written
      ack_o <= req & mapped;
      err_o <= req & ~mapped;
      dat_o <= (req & mapped & ~we_i) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ***************************************
  // registered pin outputs
  // ***************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      pa_out_o <= 8'h00;
      pb_out_o <= 8'h00;
      pc_out_o <= 8'h00;
      pd_out_o <= 8'h00;
      pa_oe_o <= 8'h00;
      pb_oe_o <= 8'h00;
      pc_oe_o <= 8'h00;
      pd_oe_o <= 8'h00;
      led_drive_o <= 7'h00;
      port_b_alt_in_o <= 8'h00;
    end else if (ce_i) begin
      pa_out_o <= out_all[7:0];
      pb_out_o <= out_all[15:8];
      pc_out_o <= out_all[23:16];
      pd_out_o <= out_all[31:24];
      pa_oe_o <= oe_all[7:0];
      pb_oe_o <= oe_all[15:8];
      pc_oe_o <= oe_all[23:16];
      pd_oe_o <= oe_all[31:24];
      // led drive only applies to pins not taken by the converter
      led_drive_o <= led_drive_enable & ~adc_mask[6:0];
      port_b_alt_in_o <= pb_sync;
    end
  end

endmodule
`default_nettype wire

// >>> sim/fpio_pin_model.sv
// fpio_pin_model.sv: pads and board around the four ports
// assumes: ext_i is what the board puts on a pin that the block leaves undriven
`timescale 1ns/100ps
`default_nettype none
module fpio_pin_model (
  input wire logic [31:0] out_i,
  input wire logic [31:0] oe_i,
  input wire logic [31:0] ext_i,
  output logic [31:0] pin_o
);
  // a released pin shows the board level, never the last driven value
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// >>> sim/fpio_top_properties.sv
// fpio_top_properties.sv: port checker for the parallel io block
// assumes: bound to fpio_top, bus master keeps the classic single cycle
`timescale 1ns/100ps
`default_nettype none
module fpio_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [7:0] pa_oe_o,
  input wire logic [7:0] pb_out_o,
  input wire logic [7:0] pb_oe_o,
  input wire logic [7:0] pd_oe_o,
  input wire logic [6:0] led_drive_o,
  input wire logic sda_out_i,
  input wire logic scl_out_i,
  input wire logic txd_out_i,
  input wire logic [1:0] ch0_edge_level_select_i,
  input wire logic t1c0_out_i,
  input wire logic t1c0_oe_i
);
  // shadows follow writes at the acknowledging edge, same edge the pins move
  logic [7:0] alt_sh;
  logic [7:0] dird_sh;
  logic [1:0] up;
  wire wr = ce_i && cyc_i && stb_i && we_i && sel_i[0] && ack_o;
  always @(posedge clk_i) begin
    if (rst_i) begin
      alt_sh <= 8'h00;
      dird_sh <= 8'h00;
      up <= 2'h0;
    end else begin
      up <= up + {1'b0, up != 2'h3};
      if (wr && adr_i[5:2] == 4'hd) alt_sh <= dat_i[7:0];
      if (wr && adr_i[5:2] == 4'h7) dird_sh <= dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_answer; cyc_i && stb_i && ce_i && !ack_o && !err_o |=> ack_o ^ err_o; endproperty
  a_answer: assert property (p_answer) else $error("request not answered next cycle");
  property p_reset_idle; $past(rst_i) |-> {pa_oe_o, pb_oe_o, pd_oe_o} == 24'h0 && led_drive_o == 7'h00; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("drivers or leds on after reset");
  property p_err_map;
    cyc_i && stb_i && ce_i && !ack_o && !err_o && adr_i[5:2] inside {4'h8, 4'h9, 4'ha, 4'hb, 4'he, 4'hf}
      |=> err_o && !ack_o;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped index not refused");
  property p_bus_od;
    (alt_sh[6] && $stable({scl_out_i, sda_out_i}))[*3] |-> pb_out_o[1:0] == 2'b00 && pb_oe_o[1:0] == ~{scl_out_i, sda_out_i};
  endproperty
  a_bus_od: assert property (p_bus_od) else $error("bus pins not open drain");
  property p_sci_od;
    (alt_sh[7] && $stable(txd_out_i))[*3] |-> pb_oe_o[3:2] == {1'b0, !txd_out_i} && pb_out_o[3:2] == 2'b00;
  endproperty
  a_sci_od: assert property (p_sci_od) else $error("serial pins not open drain");
  property p_adc_own;
    (alt_sh[5] && $stable(alt_sh))[*3] |->
      pa_oe_o[alt_sh[2:0]] == 1'b0 && ({1'b0, led_drive_o} & (8'h01 << alt_sh[2:0])) == 8'h00;
  endproperty
  a_adc_own: assert property (p_adc_own) else $error("converter pin still driven");
  property p_timer;
    (up == 2'h3 && ce_i && ch0_edge_level_select_i != 2'h0
      && $stable({ch0_edge_level_select_i, t1c0_oe_i, t1c0_out_i}))[*3]
      |-> pb_oe_o[4] == t1c0_oe_i && (!t1c0_oe_i || pb_out_o[4] == t1c0_out_i);
  endproperty
  a_timer: assert property (p_timer) else $error("timer channel pin not handed over");
  property p_dir_drive; up == 2'h3 && $stable(dird_sh) |-> pd_oe_o == dird_sh; endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("port d drivers differ from direction");
  c_bus: cover property (alt_sh[6] && pb_oe_o[0]);
  c_err: cover property (err_o);
  c_timer: cover property (ch0_edge_level_select_i != 2'h0 && pb_oe_o[4]);
endmodule
bind fpio_top fpio_top_chk fpio_top_chk_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .ack_o, .err_o, .pa_oe_o, .pb_out_o, .pb_oe_o, .pd_oe_o, .led_drive_o, .sda_out_i, .scl_out_i, .txd_out_i,
  .ch0_edge_level_select_i, .t1c0_out_i, .t1c0_oe_i);
`default_nettype wire

// >>> sim/test_fpio_top.sv
// test_fpio_top.sv: register and pin tests of the parallel io block
// assumes: pin model resolves every pad, bus tasks wait for ack or err
`timescale 1ns/100ps
`default_nettype none
module test_fpio_top;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, sda_out_i, scl_out_i, txd_out_i;
  logic t1c0_out_i, t1c0_oe_i, t1c1_out_i, t1c1_oe_i;
  logic [1:0] ch0_edge_level_select_i, ch1_edge_level_select_i;
  logic [5:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, ext, pins;
  wire [31:0] dat_o;
  wire ack_o, err_o;
  wire [7:0] pa_out_o, pb_out_o, pc_out_o, pd_out_o, pa_oe_o, pb_oe_o, pc_oe_o, pd_oe_o, port_b_alt_in_o;
  wire [6:0] led_drive_o;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  fpio_top fpio_top_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .pa_in_i(pins[7:0]), .pb_in_i(pins[15:8]), .pc_in_i(pins[23:16]), .pd_in_i(pins[31:24]),
    .pa_out_o, .pb_out_o, .pc_out_o, .pd_out_o, .pa_oe_o, .pb_oe_o, .pc_oe_o, .pd_oe_o, .led_drive_o,
    .sda_out_i, .scl_out_i, .txd_out_i, .ch0_edge_level_select_i, .ch1_edge_level_select_i,
    .t1c0_out_i, .t1c0_oe_i, .t1c1_out_i, .t1c1_oe_i, .port_b_alt_in_o);
  fpio_pin_model fpio_pin_model_inst (.out_i({pd_out_o, pc_out_o, pb_out_o, pa_out_o}),
    .oe_i({pd_oe_o, pc_oe_o, pb_oe_o, pa_oe_o}), .ext_i(ext), .pin_o(pins));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic close_out;
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // ****************
  // bus and settle tasks
  // ****************
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
    if (n >= 50) chk(8'h01, 8'h00);
    q = dat_o[7:0];
    e = err_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    wb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x, input logic xe);
    logic [7:0] q;
    logic e;
    wb(1'b0, a, 8'h00, q, e);
    chk(q, x);
    chk({7'h0, e}, {7'h0, xe});
  endtask
  // pins move one edge after the write, the input synchroniser needs two more
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    {cyc_i, stb_i, we_i, sda_out_i, scl_out_i, txd_out_i, t1c0_out_i, t1c0_oe_i, t1c1_out_i, t1c1_oe_i} = '0;
    {ch0_edge_level_select_i, ch1_edge_level_select_i, adr_i, dat_i} = '0;
    sel_i = 4'h1;
    ce_i = 1'b1;
    ext = 32'h5a3c_c3a5;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 4; i < 8; i++) rd(6'(i * 4), 8'h00, 1'b0);
    rd(6'h30, 8'h00, 1'b0);
    rd(6'h20, 8'h00, 1'b1);
    rd(6'h38, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) wr(6'(i * 4), 8'h96 ^ 8'(i));
    wr(6'h18, 8'hff);
    wr(6'h1c, 8'h0f);
    settle;
    chk(pc_oe_o, 8'hff);
    chk(pc_out_o, 8'h94);
    chk(pd_oe_o, 8'h0f);
    chk(pd_out_o, 8'h95);
    rd(6'h08, 8'h94, 1'b0);
    rd(6'h0c, (8'h95 & 8'h0f) | (8'h5a & 8'hf0), 1'b0);
    rd(6'h00, 8'ha5, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(6'h18, 8'h00, 1'b0);
    wr(6'h18, 8'hff);
    rd(6'h08, 8'h94, 1'b0);
    wr(6'h30, 8'hff);
    rd(6'h30, 8'h7f, 1'b0);
    // low byte lane off: acknowledged, nothing written
    sel_i <= 4'h0;
    wr(6'h30, 8'h00);
    sel_i <= 4'h1;
    rd(6'h30, 8'h7f, 1'b0);
    wr(6'h10, 8'hff);
    for (int c = 0; c < 8; c++) begin
      wr(6'h34, 8'h20 | 8'(c));
      settle;
      chk(pa_oe_o, ~(8'h01 << c));
      chk(pa_out_o, 8'h96);
      chk({1'b0, led_drive_o}, 8'h7f & ~(8'h01 << c));
    end
    // bus pins must ignore the gpio latch that would drive b0 high
    wr(6'h14, 8'hff);
    scl_out_i <= 1'b1;
    wr(6'h34, 8'h40);
    settle;
    chk({4'h0, pb_out_o[1:0], pb_oe_o[1:0]}, 8'h01);
    chk({6'h0, port_b_alt_in_o[1:0]}, 8'h02);
    wr(6'h34, 8'h80);
    settle;
    chk({4'h0, pb_out_o[3:2], pb_oe_o[3:2]}, 8'h01);
    chk({6'h0, pb_oe_o[1:0]}, 8'h03);
    for (int s = 1; s < 4; s++) begin
      @(posedge clk_i);
      ch0_edge_level_select_i <= 2'(s);
      ch1_edge_level_select_i <= 2'(s);
      t1c0_oe_i <= 1'b1;
      settle;
      chk({6'h0, pb_oe_o[5:4]}, 8'h01);
      chk({7'h0, pb_out_o[4]}, 8'h00);
    end
    // pins hold while the clock enable is low, then catch up
    @(posedge clk_i);
    ce_i <= 1'b0;
    t1c0_oe_i <= 1'b0;
    settle;
    chk({6'h0, pb_oe_o[5:4]}, 8'h01);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle;
    chk({6'h0, pb_oe_o[5:4]}, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
